// >>> design/uea_event_agg.v
// endpoint event and mask registers with main event summary, AXI4-Lite slave
`include "uea_regs.vh"

// Notes on behaviour
// - low nibble of transmit flags records transmit-done per endpoint
// - transmit-done flag clears when that endpoint's transmit status is read
// - high nibble of transmit flags records underflow, cleared by transmit status read
// - endpoint zero underflow flag is always zero
// - unmasked transmit flags drive the transmit summary bit
// - receive-complete flag sets on error or last-packet, cleared by receive status read
// - endpoint zero receive flag follows only last-packet, never error
// - receive overflow flags sit in high nibble, cleared by reading receive flags
// - unmasked receive flags drive the receive summary bit
// - IN refusal flag sets only with address enable and endpoint enable
// - OUT refusal flag same, but not when refusal comes from an overrun
// - reading refusal flags clears all of them
// - unmasked refusal events set the refusal summary bit
// - transmit level alert sets at threshold while transmission is enabled
// - transmit alert clears on FIFO write, flush or transmit-done
// - receive level alert sets at threshold for endpoints 1 to 3
// - receive alert clears on FIFO read or flush
// - unmasked alert events set the warning summary; bits 0 and 4 reserved
// - reading warning flags clears the warning summary bit
// - reading refusal flags clears the refusal summary bit
// - main mask bit 7 is master enable; main flag bit 7 reads zero
module uea_event_agg
(
	input  wire        clk_i,
	input  wire        srst_i,
	input  wire        ce_i,
	// axi4-lite slave
	input  wire [7:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output wire        s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output wire        s_axi_wready_o,
	output wire [1:0]  s_axi_bresp_o,
	output wire        s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [7:0]  s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output wire        s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0]  s_axi_rresp_o,
	output wire        s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	// endpoint pipe events, one bit per endpoint 0..3
	input  wire [3:0]  tx_done_i,
	input  wire [3:0]  tx_underflow_status_i,
	input  wire [3:0]  tx_stat_read_i,
	input  wire [3:0]  rx_last_i,
	input  wire [3:0]  rx_err_i,
	input  wire [3:0]  rx_overflow_i,
	input  wire [3:0]  rx_stat_read_i,
	input  wire [3:0]  nak_in_i,
	input  wire [3:0]  nak_out_i,
	input  wire [3:0]  nak_out_ovr_i,
	input  wire        addr_enable_i,
	input  wire [3:0]  endpoint_enable_i,
	// level alerts, endpoints 1..3 on bits 0..2
	input  wire [2:0]  tx_alert_threshold_hit_i,
	input  wire [2:0]  tx_enable_i,
	input  wire [2:0]  tx_fifo_write_i,
	input  wire [2:0]  tx_fifo_flush_i,
	input  wire [2:0]  rx_alert_threshold_hit_i,
	input  wire [2:0]  rx_fifo_read_i,
	input  wire [2:0]  rx_fifo_flush_i,
	// main event bits kept outside this block
	input  wire        alt_event_i,
	input  wire        frame_event_i,
	input  wire        uld_event_i,
	output wire        irq_o
);

	// one-hot register select, shared by the read and write paths
	// a miss leaves every select low, which the bus logic answers with an error
	// and the read mux with zero
	function [`UEA_NREG-1:0] reg_sel;
		input [`UEA_AW-1:0] a;
		begin
			reg_sel = {`UEA_NREG{1'b0}};
			case (a)
				`UEA_OFF_TRANSMIT_EVENT_FLAGS:   reg_sel[`UEA_SEL_TRANSMIT_EVENT_FLAGS] = 1'b1;
				`UEA_OFF_TRANSMIT_EVENT_MASK:  reg_sel[`UEA_SEL_TRANSMIT_EVENT_MASK] = 1'b1;
				`UEA_OFF_RECEIVE_EVENT_FLAGS:   reg_sel[`UEA_SEL_RECEIVE_EVENT_FLAGS] = 1'b1;
				`UEA_OFF_RECEIVE_EVENT_MASK:  reg_sel[`UEA_SEL_RECEIVE_EVENT_MASK] = 1'b1;
				`UEA_OFF_HANDSHAKE_REFUSAL_FLAGS:  reg_sel[`UEA_SEL_HANDSHAKE_REFUSAL_FLAGS] = 1'b1;
				`UEA_OFF_HANDSHAKE_REFUSAL_MASK: reg_sel[`UEA_SEL_HANDSHAKE_REFUSAL_MASK] = 1'b1;
				`UEA_OFF_FIFO_LEVEL_WARNING_FLAGS:   reg_sel[`UEA_SEL_FIFO_LEVEL_WARNING_FLAGS] = 1'b1;
				`UEA_OFF_FIFO_LEVEL_WARNING_MASK:  reg_sel[`UEA_SEL_FIFO_LEVEL_WARNING_MASK] = 1'b1;
				`UEA_OFF_MAIN_EVENT_FLAGS:   reg_sel[`UEA_SEL_MAIN_EVENT_FLAGS] = 1'b1;
				`UEA_OFF_MAIN_EVENT_MASK:  reg_sel[`UEA_SEL_MAIN_EVENT_MASK] = 1'b1;
				default:         reg_sel = {`UEA_NREG{1'b0}};
			endcase
		end
	endfunction

	// bus state
	// write address and data may arrive apart; the got flags hold the early one
	// only byte lane 0 carries register data, the upper lanes are ignored
	reg                 awready_r;
	reg                 wready_r;
	reg                 bvalid_r;
	reg  [1:0]          bresp_r;
	reg                 arready_r;
	reg                 rvalid_r;
	reg  [1:0]          rresp_r;
	reg  [31:0]         rdata_r;
	reg                 aw_got_r;
	reg                 w_got_r;
	reg  [`UEA_AW-1:0]  awaddr_r;
	reg  [7:0]          wdata_r;
	reg                 wlane_r;

	// event and mask state
	// each flag kind but the in and out refusals keeps its own register so set and clear terms stay per endpoint
	reg  [3:0]          tx_complete_copy_r;
	reg  [3:0]          tx_underflow_copy_r;
	reg  [3:0]          rx_complete_event_r;
	reg  [3:0]          rx_overflow_event_r;
	reg  [7:0]          handshake_refusal_flags_r;
	reg  [2:0]          tx_level_alert_r;
	reg  [2:0]          rx_level_alert_r;
	reg                 nak_sum_r;
	reg                 warn_sum_r;
	reg  [7:0]          transmit_event_mask_r;
	reg  [7:0]          receive_event_mask_r;
	reg  [7:0]          handshake_refusal_mask_r;
	reg  [7:0]          fifo_level_warning_mask_r;
	reg  [7:0]          main_event_mask_r;
	reg                 irq_r;

	// handshakes on the five channels
	// wr_do fires once both halves are present and no response is waiting;
	// holding it back while bvalid stands keeps one write in flight at a time
	wire                aw_fire = s_axi_awvalid_i & awready_r;
	wire                w_fire = s_axi_wvalid_i & wready_r;
	wire                ar_fire = s_axi_arvalid_i & arready_r;
	wire                aw_have = aw_got_r | aw_fire;
	wire                w_have = w_got_r | w_fire;
	wire                wr_do = aw_have & w_have & ~bvalid_r;
	// a beat taken earlier comes from its holding register, else straight from the bus
	wire [`UEA_AW-1:0]  wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr_i;
	wire [7:0]          wr_data = w_got_r ? wdata_r : s_axi_wdata_i[7:0];
	wire                wr_lane = w_got_r ? wlane_r : s_axi_wstrb_i[0];
	wire [`UEA_NREG-1:0] wsel = reg_sel(wr_addr);
	wire [`UEA_NREG-1:0] rsel = reg_sel(s_axi_araddr_i);
	wire                wr_en = wr_do & wr_lane;
	wire                bvalid_nxt = wr_do | (bvalid_r & ~s_axi_bready_i);
	wire                rvalid_nxt = ar_fire | (rvalid_r & ~s_axi_rready_i);
	wire                aw_got_nxt = aw_have & ~wr_do;
	wire                w_got_nxt = w_have & ~wr_do;

	// read side effects happen when the address is taken
	// clearing on the address edge means a stalled rready cannot lose an event:
	// the data returned already holds the value captured before the clear
	wire                rd_receive_event_flags = ar_fire & rsel[`UEA_SEL_RECEIVE_EVENT_FLAGS];
	wire                rd_handshake_refusal_flags = ar_fire & rsel[`UEA_SEL_HANDSHAKE_REFUSAL_FLAGS];
	wire                rd_fifo_level_warning_flags = ar_fire & rsel[`UEA_SEL_FIFO_LEVEL_WARNING_FLAGS];

	// transmit flags; set terms are or-ed last so a same-cycle event beats the clear
	// endpoint zero cannot underflow because it stores a whole packet first
	wire [3:0] tx_complete_copy_nxt = (tx_complete_copy_r & ~tx_stat_read_i)
		| tx_done_i;
	wire [3:0] tx_underflow_copy_nxt = ((tx_underflow_copy_r & ~tx_stat_read_i)
		| tx_underflow_status_i) & `UEA_EP0_CLR;

	// receive flags; endpoint zero errors never raise the flag
	// a corrupted control packet is dropped so a repeated setup can still land
	wire [3:0] rx_set = rx_last_i | (rx_err_i & `UEA_EP0_CLR);
	wire [3:0] rx_complete_event_nxt = (rx_complete_event_r & ~rx_stat_read_i)
		| rx_set;
	// overflow clears on a read of the receive flags, unlike the complete bits
	wire [3:0] rx_overflow_event_nxt = (rd_receive_event_flags ? 4'h0 : rx_overflow_event_r)
		| rx_overflow_i;

	// refusal flags need both the address and the endpoint enabled
	// an OUT refusal caused by an overrun already shows as an overflow flag,
	// so it is kept out of the refusal flags
	wire [3:0] nak_ok = {4{addr_enable_i}} & endpoint_enable_i;
	wire [3:0] nak_in_set = nak_in_i & nak_ok;
	wire [3:0] nak_out_set = nak_out_i & ~nak_out_ovr_i & nak_ok;
	// in and out refusals share one register, in below out
	wire [7:0] nak_set = {nak_out_set, nak_in_set};
	wire [7:0] handshake_refusal_flags_nxt =
		(rd_handshake_refusal_flags ? 8'h00 : handshake_refusal_flags_r) | nak_set;

	// level alerts for endpoints 1..3
	// the threshold compare lives with the fifo; this block only sees its hit strobe
	// a set in the same cycle as a clear wins, so a fresh hit is never lost
	wire [2:0] txw_set = tx_alert_threshold_hit_i & tx_enable_i;
	// transmit-done of endpoints 1..3 also ends their warning
	wire [2:0] txw_clr = tx_fifo_write_i | tx_fifo_flush_i | tx_done_i[3:1];
	wire [2:0] tx_level_alert_nxt = (tx_level_alert_r & ~txw_clr) | txw_set;
	wire [2:0] rxw_set = rx_alert_threshold_hit_i;
	wire [2:0] rxw_clr = rx_fifo_read_i | rx_fifo_flush_i;
	wire [2:0] rx_level_alert_nxt = (rx_level_alert_r & ~rxw_clr) | rxw_set;

	// assembled views of the flag registers
	// reserved warning positions are tied low here and in the mask
	wire [7:0] transmit_event_flags = {tx_underflow_copy_r, tx_complete_copy_r};
	wire [7:0] receive_event_flags = {rx_overflow_event_r, rx_complete_event_r};
	wire [7:0] fifo_level_warning_flags = {rx_level_alert_r, 1'b0,
		tx_level_alert_r, 1'b0};
	wire [7:0] fw_set = {rxw_set, 1'b0, txw_set, 1'b0};

	// summaries: transmit and receive follow the masked flags as levels
	// refusal and warning summaries are sticky: they latch an unmasked event
	// as it occurs and drop only when their flag register is read; unmasking
	// an old flag later does not raise them
	wire tx_sum = |(transmit_event_flags & transmit_event_mask_r);
	wire rx_sum = |(receive_event_flags & receive_event_mask_r);
	wire nak_hit = |(nak_set & handshake_refusal_mask_r);
	wire fw_hit = |(fw_set & fifo_level_warning_mask_r & `UEA_FW_MASK);
	wire nak_sum_nxt = (nak_sum_r & ~rd_handshake_refusal_flags) | nak_hit;
	wire warn_sum_nxt = (warn_sum_r & ~rd_fifo_level_warning_flags) | fw_hit;

	// main flags; bit 7 is not a flag and always reads zero
	// alternate, frame and unlock bits come from logic outside this block
	wire [7:0] main_event_flags = {1'b0, rx_sum, uld_event_i, nak_sum_r,
		frame_event_i, tx_sum, alt_event_i, warn_sum_r};
	// registered so the request pin is glitch free; it lags its cause by one edge
	wire irq_nxt = main_event_mask_r[`UEA_MAIN_EVENT_FLAGS_MASTER_IRQ_ENABLE]
		& |(main_event_flags[6:0] & main_event_mask_r[6:0]);

	// read data mux, unmapped addresses return zero
	// driven from the one-hot select so the priority order never matters
	reg  [7:0] rd_mux;
	always @*
	begin
		rd_mux = 8'h00;
		case (1'b1)
			rsel[`UEA_SEL_TRANSMIT_EVENT_FLAGS]:   rd_mux = transmit_event_flags;
			rsel[`UEA_SEL_TRANSMIT_EVENT_MASK]:  rd_mux = transmit_event_mask_r;
			rsel[`UEA_SEL_RECEIVE_EVENT_FLAGS]:   rd_mux = receive_event_flags;
			rsel[`UEA_SEL_RECEIVE_EVENT_MASK]:  rd_mux = receive_event_mask_r;
			rsel[`UEA_SEL_HANDSHAKE_REFUSAL_FLAGS]:  rd_mux = handshake_refusal_flags_r;
			rsel[`UEA_SEL_HANDSHAKE_REFUSAL_MASK]: rd_mux = handshake_refusal_mask_r;
			rsel[`UEA_SEL_FIFO_LEVEL_WARNING_FLAGS]:   rd_mux = fifo_level_warning_flags;
			rsel[`UEA_SEL_FIFO_LEVEL_WARNING_MASK]:  rd_mux = fifo_level_warning_mask_r;
			rsel[`UEA_SEL_MAIN_EVENT_FLAGS]:   rd_mux = main_event_flags;
			rsel[`UEA_SEL_MAIN_EVENT_MASK]:  rd_mux = main_event_mask_r;
			default:               rd_mux = 8'h00;
		endcase
	end

	// bus slave; all state freezes while ce_i is low
	// readies are registered, so each channel is refused for the cycle after
	// a transfer and the master must wait for ready before counting a beat
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `UEA_RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= `UEA_RESP_OKAY;
			rdata_r   <= 32'h00000000;
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 8'h00;
			wlane_r   <= 1'b0;
		end
		else if (ce_i)
		begin
			// ready drops while a channel is held or a response waits
			awready_r <= ~aw_got_nxt & ~bvalid_nxt;
			wready_r  <= ~w_got_nxt & ~bvalid_nxt;
			arready_r <= ~rvalid_nxt;
			aw_got_r  <= aw_got_nxt;
			w_got_r   <= w_got_nxt;
			bvalid_r  <= bvalid_nxt;
			rvalid_r  <= rvalid_nxt;
			if (aw_fire)
				awaddr_r <= s_axi_awaddr_i;
			if (w_fire)
			begin
				wdata_r <= s_axi_wdata_i[7:0];
				wlane_r <= s_axi_wstrb_i[0];
			end
			// the response code stands until the next write completes
			if (wr_do)
				bresp_r <= (|wsel) ? `UEA_RESP_OKAY : `UEA_RESP_SLVERR;
			// read data is captured once at the address edge and held while rvalid stands
			if (ar_fire)
			begin
				rdata_r <= {24'h000000, rd_mux};
				rresp_r <= (|rsel) ? `UEA_RESP_OKAY : `UEA_RESP_SLVERR;
			end
		end
	end

	// mask registers, written through byte lane 0 only
	// reserved warning mask bits cannot be set, so they always read back zero
	// a write with byte lane 0 off is answered but changes nothing
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			transmit_event_mask_r     <= `UEA_RST8;
			receive_event_mask_r      <= `UEA_RST8;
			handshake_refusal_mask_r  <= `UEA_RST8;
			fifo_level_warning_mask_r <= `UEA_RST8;
			main_event_mask_r         <= `UEA_RST8;
		end
		else if (ce_i && wr_en)
		begin
			if (wsel[`UEA_SEL_TRANSMIT_EVENT_MASK])
				transmit_event_mask_r <= wr_data;
			if (wsel[`UEA_SEL_RECEIVE_EVENT_MASK])
				receive_event_mask_r <= wr_data;
			if (wsel[`UEA_SEL_HANDSHAKE_REFUSAL_MASK])
				handshake_refusal_mask_r <= wr_data;
			if (wsel[`UEA_SEL_FIFO_LEVEL_WARNING_MASK])
				fifo_level_warning_mask_r <= wr_data & `UEA_FW_MASK;
			if (wsel[`UEA_SEL_MAIN_EVENT_MASK])
				main_event_mask_r <= wr_data;
		end
	end

	// event flags and summaries; writes to flag registers are ignored
	// flag registers are read-only to software; a write there only gets OKAY
	// while ce_i is low every flag holds and strobes arriving then are lost,
	// so the pipes must keep the enable high while they raise events
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			tx_complete_copy_r        <= 4'h0;
			tx_underflow_copy_r       <= 4'h0;
			rx_complete_event_r       <= 4'h0;
			rx_overflow_event_r       <= 4'h0;
			handshake_refusal_flags_r <= `UEA_RST8;
			tx_level_alert_r          <= 3'h0;
			rx_level_alert_r          <= 3'h0;
			nak_sum_r                 <= 1'b0;
			warn_sum_r                <= 1'b0;
			irq_r                     <= 1'b0;
		end
		else if (ce_i)
		begin
			tx_complete_copy_r        <= tx_complete_copy_nxt;
			tx_underflow_copy_r       <= tx_underflow_copy_nxt;
			rx_complete_event_r       <= rx_complete_event_nxt;
			rx_overflow_event_r       <= rx_overflow_event_nxt;
			handshake_refusal_flags_r <= handshake_refusal_flags_nxt;
			tx_level_alert_r          <= tx_level_alert_nxt;
			rx_level_alert_r          <= rx_level_alert_nxt;
			nak_sum_r                 <= nak_sum_nxt;
			warn_sum_r                <= warn_sum_nxt;
			irq_r                     <= irq_nxt;
		end
	end

	// all outputs straight from flops
	// nothing combinational reaches a pin
	assign s_axi_awready_o = awready_r;
	assign s_axi_wready_o  = wready_r;
	assign s_axi_bvalid_o  = bvalid_r;
	assign s_axi_bresp_o   = bresp_r;
	assign s_axi_arready_o = arready_r;
	assign s_axi_rvalid_o  = rvalid_r;
	assign s_axi_rresp_o   = rresp_r;
	assign s_axi_rdata_o   = rdata_r;
	assign irq_o           = irq_r;

endmodule // uea_event_agg

// >>> design/uea_regs.vh
// register offsets, field positions and reset values of the endpoint event aggregator
`ifndef UEA_REGS_VH
`define UEA_REGS_VH

`define UEA_AW            8
`define UEA_OFF_TRANSMIT_EVENT_FLAGS      8'h00
`define UEA_OFF_TRANSMIT_EVENT_MASK     8'h04
`define UEA_OFF_RECEIVE_EVENT_FLAGS      8'h08
`define UEA_OFF_RECEIVE_EVENT_MASK     8'h0C
`define UEA_OFF_HANDSHAKE_REFUSAL_FLAGS     8'h10
`define UEA_OFF_HANDSHAKE_REFUSAL_MASK    8'h14
`define UEA_OFF_FIFO_LEVEL_WARNING_FLAGS      8'h18
`define UEA_OFF_FIFO_LEVEL_WARNING_MASK     8'h1C
`define UEA_OFF_MAIN_EVENT_FLAGS      8'h20
`define UEA_OFF_MAIN_EVENT_MASK     8'h24

`define UEA_NREG          10
`define UEA_SEL_TRANSMIT_EVENT_FLAGS      0
`define UEA_SEL_TRANSMIT_EVENT_MASK     1
`define UEA_SEL_RECEIVE_EVENT_FLAGS      2
`define UEA_SEL_RECEIVE_EVENT_MASK     3
`define UEA_SEL_HANDSHAKE_REFUSAL_FLAGS     4
`define UEA_SEL_HANDSHAKE_REFUSAL_MASK    5
`define UEA_SEL_FIFO_LEVEL_WARNING_FLAGS      6
`define UEA_SEL_FIFO_LEVEL_WARNING_MASK     7
`define UEA_SEL_MAIN_EVENT_FLAGS      8
`define UEA_SEL_MAIN_EVENT_MASK     9

`define UEA_MAIN_EVENT_FLAGS_WARN     0
`define UEA_MAIN_EVENT_FLAGS_ALT      1
`define UEA_MAIN_EVENT_FLAGS_TX       2
`define UEA_MAIN_EVENT_FLAGS_FRAME    3
`define UEA_MAIN_EVENT_FLAGS_NAK      4
`define UEA_MAIN_EVENT_FLAGS_ULD      5
`define UEA_MAIN_EVENT_FLAGS_RX       6
`define UEA_MAIN_EVENT_FLAGS_MASTER_IRQ_ENABLE     7

`define UEA_RST8          8'h00
`define UEA_EP0_CLR       4'hE
`define UEA_FW_MASK       8'hEE
`define UEA_RESP_OKAY     2'b00
`define UEA_RESP_SLVERR   2'b10

`endif

// >>> tb/testbench.sv
// self-checking bench for the endpoint event aggregator
`include "uea_regs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TXD = 0, TXU = 1, TXS = 2, RXL = 3, RXE = 4, RXO = 5, RXS = 6, NIN = 7;
	localparam int NOUT = 8, TXH = 9, TXW = 10, RXH = 12, RXR = 13, RXF = 14;
	logic             clk_i = 0, srst_i = 1, go = 0, ae = 0;
	logic             awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [7:0]       awaddr = 0, araddr = 0;
	logic [31:0]      wdata = 0, rdata;
	logic [3:0]       sel = 0, epm = 0, ovr = 0, endpoint_enable = 0;
	logic [2:0]       tx_en = 0;
	logic [15:0][3:0] ev;
	logic [1:0]       bresp, rresp;
	logic             awr, wr_r, bv, arr, rv, irq;
	int               n_fail = 0, checks = 0, cyc = 0;

	uea_pipe_model u_pipe (.clk_i(clk_i), .go_i(go), .sel_i(sel), .ep_i(epm), .ev_o(ev));
	uea_event_agg dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
		.tx_done_i(ev[0]), .tx_underflow_status_i(ev[1]), .tx_stat_read_i(ev[2]),
		.rx_last_i(ev[3]), .rx_err_i(ev[4]), .rx_overflow_i(ev[5]), .rx_stat_read_i(ev[6]),
		.nak_in_i(ev[7]), .nak_out_i(ev[8]), .nak_out_ovr_i(ovr), .addr_enable_i(ae),
		.endpoint_enable_i(endpoint_enable), .tx_alert_threshold_hit_i(ev[9][2:0]), .tx_enable_i(tx_en),
		.tx_fifo_write_i(ev[10][2:0]), .tx_fifo_flush_i(ev[11][2:0]),
		.rx_alert_threshold_hit_i(ev[12][2:0]), .rx_fifo_read_i(ev[13][2:0]),
		.rx_fifo_flush_i(ev[14][2:0]), .alt_event_i(1'b0), .frame_event_i(1'b0),
		.uld_event_i(1'b0), .irq_o(irq));

	// free-running clock, 25 ns period
	always #12.5 clk_i = ~clk_i;

	task automatic final_report();
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// one bus transfer; every channel held until its own ready is sampled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic [1:0] r);
		@(posedge clk_i);
		awaddr <= a;
		araddr <= a;
		wdata <= {24'h0, d};
		awv <= w;
		wv <= w;
		bry <= w;
		arv <= !w;
		rry <= !w;
		do
		begin
			@(posedge clk_i);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
			if (arr) arv <= 1'b0;
		end
		while (!(w ? bv : rv));
		q = rdata;
		r = w ? bresp : rresp;
		bry <= 1'b0;
		rry <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
		logic [31:0] q;
		logic [1:0]  r;
		xfer(1'b0, a, 8'h00, q, r);
		chk(q, e);
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
		logic [31:0] q;
		logic [1:0]  r;
		xfer(1'b1, a, d, q, r);
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic ev_req(input int s, input logic [3:0] m);
		@(posedge clk_i);
		sel <= s[3:0];
		epm <= m;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
	endtask

	// irq_o lags its cause by a register stage, so let one edge pass
	task automatic chki(input logic e);
		@(posedge clk_i);
		chk({31'h0, irq}, {31'h0, e});
	endtask

	// hang guard well above the length of the sequence
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			final_report();
		end
	end

	initial
	begin
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		for (int i = 0; i < 10; i++) rd(8'(4 * i), 32'h0);
		rd(8'h28, 32'h0, 2'b10);
		wr(8'h28, 8'hFF, 2'b10);
		wr(`UEA_OFF_TRANSMIT_EVENT_MASK, 8'hFF);
		wr(`UEA_OFF_MAIN_EVENT_MASK, 8'h84);
		ev_req(TXD, 4'hF);
		rd(`UEA_OFF_TRANSMIT_EVENT_FLAGS, 8'h0F);
		rd(`UEA_OFF_MAIN_EVENT_FLAGS, 8'h04);
		chki(1'b1);
		ev_req(TXS, 4'h5);
		wr(`UEA_OFF_TRANSMIT_EVENT_FLAGS, 8'h00);
		rd(`UEA_OFF_TRANSMIT_EVENT_FLAGS, 8'h0A);
		ev_req(TXU, 4'hF);
		rd(`UEA_OFF_TRANSMIT_EVENT_FLAGS, 8'hEA);
		ev_req(TXS, 4'hF);
		wr(`UEA_OFF_TRANSMIT_EVENT_MASK, 8'h0F);
		ev_req(TXU, 4'h2);
		rd(`UEA_OFF_MAIN_EVENT_FLAGS, 8'h00);
		ev_req(TXS, 4'h2);
		ev_req(RXE, 4'hF);
		rd(`UEA_OFF_RECEIVE_EVENT_FLAGS, 8'h0E);
		ev_req(RXL, 4'h1);
		rd(`UEA_OFF_MAIN_EVENT_FLAGS, 8'h00);
		wr(`UEA_OFF_RECEIVE_EVENT_MASK, 8'h01);
		rd(`UEA_OFF_MAIN_EVENT_FLAGS, 8'h40);
		ev_req(RXO, 4'hA);
		rd(`UEA_OFF_RECEIVE_EVENT_FLAGS, 8'hAF);
		rd(`UEA_OFF_RECEIVE_EVENT_FLAGS, 8'h0F);
		ev_req(RXS, 4'hF);
		rd(`UEA_OFF_RECEIVE_EVENT_FLAGS, 8'h00);
		endpoint_enable <= 4'hF;
		ev_req(NIN, 4'hF);
		rd(`UEA_OFF_HANDSHAKE_REFUSAL_FLAGS, 8'h00);
		ae <= 1'b1;
		endpoint_enable <= 4'h3;
		ovr <= 4'h1;
		ev_req(NIN, 4'hF);
		ev_req(NOUT, 4'hF);
		rd(`UEA_OFF_MAIN_EVENT_FLAGS, 8'h00);
		rd(`UEA_OFF_HANDSHAKE_REFUSAL_FLAGS, 8'h23);
		rd(`UEA_OFF_HANDSHAKE_REFUSAL_FLAGS, 8'h00);
		wr(`UEA_OFF_HANDSHAKE_REFUSAL_MASK, 8'h01);
		ev_req(NIN, 4'h1);
		rd(`UEA_OFF_MAIN_EVENT_FLAGS, 8'h10);
		// the refusal summary is not enabled in the main mask, so no request
		chki(1'b0);
		rd(`UEA_OFF_HANDSHAKE_REFUSAL_FLAGS, 8'h01);
		rd(`UEA_OFF_MAIN_EVENT_FLAGS, 8'h00);
		wr(`UEA_OFF_FIFO_LEVEL_WARNING_MASK, 8'hFF);
		rd(`UEA_OFF_FIFO_LEVEL_WARNING_MASK, 8'hEE);
		tx_en <= 3'b101;
		ev_req(TXH, 4'h7);
		// summary checks first: reading the warning flags clears the summary
		rd(`UEA_OFF_MAIN_EVENT_FLAGS, 8'h01);
		chki(1'b0);
		wr(`UEA_OFF_MAIN_EVENT_MASK, 8'h7F);
		chki(1'b0);
		wr(`UEA_OFF_MAIN_EVENT_MASK, 8'hFF);
		chki(1'b1);
		rd(`UEA_OFF_FIFO_LEVEL_WARNING_FLAGS, 8'h0A);
		rd(`UEA_OFF_MAIN_EVENT_FLAGS, 8'h00);
		ev_req(TXW, 4'h1);
		rd(`UEA_OFF_FIFO_LEVEL_WARNING_FLAGS, 8'h08);
		ev_req(TXD, 4'h8);
		rd(`UEA_OFF_FIFO_LEVEL_WARNING_FLAGS, 8'h00);
		ev_req(TXS, 4'h8);
		ev_req(RXH, 4'h7);
		rd(`UEA_OFF_FIFO_LEVEL_WARNING_FLAGS, 8'hE0);
		ev_req(RXR, 4'h1);
		ev_req(RXF, 4'h2);
		rd(`UEA_OFF_FIFO_LEVEL_WARNING_FLAGS, 8'h80);
		rd(`UEA_OFF_MAIN_EVENT_FLAGS, 8'h00);
		final_report();
	end
endmodule // testbench

// >>> tb/uea_event_agg_monitor.sv
// checker on the register bus and read-back fields of the event aggregator
`include "uea_regs.vh"
module uea_monitor
(
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic        ce_i,
	input wire logic [7:0]  s_axi_araddr_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ra_r;
	wire        ar_hs = s_axi_arvalid_i && s_axi_arready_o && ce_i;
	wire        w_hs  = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;

	// keep the taken read address so returned data can be judged per register
	always @(posedge clk_i)
	begin
		if (ar_hs)
			ra_r <= s_axi_araddr_i;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_rd_answer: assert property (ar_hs |=> s_axi_rvalid_o) else $error("read answer late");
	a_wr_answer: assert property (w_hs && ce_i |=> s_axi_bvalid_o) else $error("write answer late");
	a_rd_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
		&& $stable(s_axi_rdata_o)) else $error("read data dropped");
	a_ar_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("ar ready early");
	a_w_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("aw or w ready early");
	a_master_bit_zero: assert property (s_axi_rvalid_o && ra_r == `UEA_OFF_MAIN_EVENT_FLAGS
		|-> !s_axi_rdata_o[7]) else $error("main flag bit 7 set");
	a_ep0_underflow: assert property (s_axi_rvalid_o && ra_r == `UEA_OFF_TRANSMIT_EVENT_FLAGS
		|-> !s_axi_rdata_o[4]) else $error("ep0 underflow flag set");
	a_warn_reserved: assert property (s_axi_rvalid_o && ra_r[7:3] == 5'h03
		|-> !s_axi_rdata_o[0] && !s_axi_rdata_o[4]) else $error("reserved warning bit set");
	a_unmapped_read: assert property (s_axi_rvalid_o && ra_r > `UEA_OFF_MAIN_EVENT_MASK
		|-> s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0) else $error("unmapped read");
	c_write: cover property (w_hs);
	c_read: cover property (ar_hs);
	c_irq: cover property ($rose(irq_o));
endmodule // uea_monitor

bind uea_event_agg uea_monitor u_mon (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
	.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i), .s_axi_awvalid_i(s_axi_awvalid_i),
	.s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
	.s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i), .irq_o(irq_o));

// >>> tb/uea_pipe_model.sv
// behavioural endpoint pipes and fifos: one-cycle event strobes on request
module uea_pipe_model
(
	input  wire logic             clk_i,
	input  wire logic             go_i,
	input  wire logic [3:0]       sel_i,
	input  wire logic [3:0]       ep_i,
	output logic      [15:0][3:0] ev_o = '0
);
	timeunit 1ns;
	timeprecision 1ps;
	// strobes last one cycle as from the pipes; a slow pipe is a later request
	always @(posedge clk_i)
	begin
		ev_o <= '0;
		if (go_i)
			ev_o[sel_i] <= ep_i;
	end
endmodule // uea_pipe_model
